// ==== core/ldoc_dim_gen.v ====
`timescale 1ns/100ps
`include "ldoc_map.vh"

// internal dimming generator: 200 steps per period
module ldoc_dim_gen (
   input wire clk_sys,
   input wire rst,
   input wire run,
   input wire [1:0] freq_sel,
   input wire [7:0] duty,
   output reg dim_out
);

   reg [10:0] step_cnt;
   reg [7:0] phase;
   reg [10:0] step_last;

   // clock cycles per duty step, minus one
   function [10:0] step_len;
      input [1:0] sel;
      integer hz;
      integer cyc;
      begin
         case (sel)
            2'h0: hz = `LDOC_PWM_HZ_0;
            2'h1: hz = `LDOC_PWM_HZ_1;
            2'h2: hz = `LDOC_PWM_HZ_2;
            default: hz = `LDOC_PWM_HZ_3;
         endcase
         // slowest rate needs 1249, so eleven bits always hold it
         cyc = `LDOC_CLK_HZ / (hz * `LDOC_DUTY_STEPS) - 1;
         step_len = cyc[10:0];
      end
   endfunction

   always @* begin
      step_last = step_len(freq_sel);
   end

   // time base and period counter; new frequency applies to the step in progress
   always @(posedge clk_sys) begin
      if (rst || !run) begin
         step_cnt <= 11'h000;
         phase <= 8'h00;
         dim_out <= 1'b0;
      end else begin
         if (step_cnt >= step_last) begin
            step_cnt <= 11'h000;
            if (phase == `LDOC_DUTY_STEPS - 8'h01) begin
               phase <= 8'h00;
            end else begin
               phase <= phase + 8'h01;
            end
         end else begin
            step_cnt <= step_cnt + 11'h001;
         end
         // codes above 200 act as full on
         dim_out <= (phase < duty);
      end
   end

endmodule

// ==== core/ldoc_map.vh ====
// Functional notes
// - cut low-side conduction at peak current limit
// - over 64 limit cycles: drives off, faults low
// - hiccup expiry restarts through soft start
// - short enable low: LEDs off, gates off
// - long enable low enters standby
// - internal dimming if bit set or pin low
// - internal dimming enable bit resets to zero
// - active dimming high turns LED switch on
// - two-bit field selects gate drive current
// - drive strength same for both sources
// - internal duty 0 to 100 percent, half-percent steps
// - two-bit field selects 200 to 350 Hz
// - enable input doubles as external pulse stream
// - two-bit field selects 5 to 20 ms soft start
`ifndef LDOC_MAP_VH
`define LDOC_MAP_VH

// register byte offsets
`define LDOC_OFS_CONFIG 12'h000
`define LDOC_OFS_DUTY 12'h004
`define LDOC_OFS_STATE 12'h008
`define LDOC_OFS_IRQ_STS 12'h00C
`define LDOC_OFS_IRQ_MASK 12'h010

// dim_config_register fields
`define LDOC_CFG_INT_EN 0
`define LDOC_CFG_FREQ_LO 1
`define LDOC_CFG_FREQ_HI 2
`define LDOC_CFG_DRV_LO 3
`define LDOC_CFG_DRV_HI 4
`define LDOC_CFG_SS_LO 5
`define LDOC_CFG_SS_HI 6
`define LDOC_CFG_RESET 7'h00

// duty register
`define LDOC_DUTY_RESET 8'h00
`define LDOC_DUTY_STEPS 8'hC8

// interrupt status bits
`define LDOC_IRQ_SHUTDOWN 0
`define LDOC_IRQ_RESTART 1
`define LDOC_IRQ_STANDBY 2
`define LDOC_IRQ_LIMIT 3
`define LDOC_IRQ_RESET 4'h0

// timing
`define LDOC_CLK_HZ 50000000
`define LDOC_CLK_MHZ 50
`define LDOC_HICCUP_US 10000
`define LDOC_STANDBY_US 20000
`define LDOC_SS_STEP_US 5000
`define LDOC_OC_LIMIT_CYCLES 7'h40
`define LDOC_PWM_HZ_0 200
`define LDOC_PWM_HZ_1 250
`define LDOC_PWM_HZ_2 300
`define LDOC_PWM_HZ_3 350

`endif

// ==== core/ldoc_top.v ====
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "ldoc_map.vh"

// led dimming and overcurrent control
module ldoc_top #(
   parameter [23:0] HICCUP_CYCLES = `LDOC_HICCUP_US * `LDOC_CLK_MHZ,
   parameter [23:0] STANDBY_CYCLES = `LDOC_STANDBY_US * `LDOC_CLK_MHZ,
   parameter [23:0] SS_STEP_CYCLES = `LDOC_SS_STEP_US * `LDOC_CLK_MHZ
) (
   input wire clk_sys,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire en_dim_pin,
   input wire dim_source_select_n,
   input wire switch_clock_pin,
   input wire switch_current_sense,
   input wire loop_on_request,
   output reg low_side_gate,
   output reg high_side_gate,
   output reg dim_switch_gate_out,
   output reg [1:0] dim_gate_drive_strength,
   output reg fault_flag_1_n,
   output reg fault_flag_2_n,
   output reg standby,
   output reg soft_start_active,
   output reg irq
);

   // converter states
   localparam [1:0] ST_STANDBY = 2'h0;
   localparam [1:0] ST_SOFT = 2'h1;
   localparam [1:0] ST_RUN = 2'h2;
   localparam [1:0] ST_HICCUP = 2'h3;

   reg [1:0] state;
   reg [1:0] next_state;
   reg [6:0] cfg;
   reg [7:0] duty;
   reg [3:0] irq_sts;
   reg [3:0] irq_mask;
   reg [3:0] irq_set;

   // pin synchronisers, first stage read only by second
   reg en_meta;
   reg en_sync;
   reg sel_meta;
   reg sel_sync;
   reg swc_meta;
   reg swc_sync;
   reg swc_prev;
   reg cs_meta;
   reg cs_sync;
   reg req_meta;
   reg req_sync;

   reg [23:0] low_cnt;
   reg [23:0] tmr;
   reg [6:0] oc_cnt;
   reg oc_seen;
   reg limit_hit;
   reg [1:0] ss_sel_latched;

   wire sw_tick;
   wire use_internal;
   wire gen_out;
   wire dim_active;
   wire en_long_low;
   wire tmr_done;
   wire oc_trip;
   wire [23:0] ss_cycles;

   wire apb_access;
   wire apb_wr;
   wire [31:0] rd_word;
   wire addr_ok;

   // two-flop synchronisers for all pins
   always @(posedge clk_sys) begin
      if (rst) begin
         en_meta <= 1'b0;
         en_sync <= 1'b0;
         sel_meta <= 1'b1;
         sel_sync <= 1'b1;
         swc_meta <= 1'b0;
         swc_sync <= 1'b0;
         swc_prev <= 1'b0;
         cs_meta <= 1'b0;
         cs_sync <= 1'b0;
         req_meta <= 1'b0;
         req_sync <= 1'b0;
      end else begin
         en_meta <= en_dim_pin;
         en_sync <= en_meta;
         sel_meta <= dim_source_select_n;
         sel_sync <= sel_meta;
         swc_meta <= switch_clock_pin;
         swc_sync <= swc_meta;
         swc_prev <= swc_sync;
         cs_meta <= switch_current_sense;
         cs_sync <= cs_meta;
         req_meta <= loop_on_request;
         req_sync <= req_meta;
      end
   end

   // rising edge of the switching clock opens a new cycle
   assign sw_tick = swc_sync & ~swc_prev;

   // source choice: bit overrides pin toward internal
   assign use_internal = cfg[`LDOC_CFG_INT_EN] | ~sel_sync;

   // internal generator runs only while selected and enabled
   ldoc_dim_gen u_gen (
      .clk_sys(clk_sys),
      .rst(rst),
      .run(use_internal & en_sync),
      .freq_sel(cfg[`LDOC_CFG_FREQ_HI:`LDOC_CFG_FREQ_LO]),
      .duty(duty),
      .dim_out(gen_out)
   );

   // enable input is also the external pulse stream
   assign dim_active = use_internal ? (gen_out & en_sync) : en_sync;

   // a low enable only counts as standby once it outlasts the entry time
   assign en_long_low = (low_cnt >= STANDBY_CYCLES);

   always @(posedge clk_sys) begin
      if (rst) begin
         low_cnt <= 24'h000000;
      end else if (en_sync) begin
         low_cnt <= 24'h000000;
      end else if (!en_long_low) begin
         low_cnt <= low_cnt + 24'h000001;
      end
   end

   // soft start length follows the latched selection
   assign ss_cycles = SS_STEP_CYCLES * ({22'h000000, ss_sel_latched} + 24'h000001);
   assign tmr_done = (state == ST_HICCUP) ? (tmr >= HICCUP_CYCLES - 24'h000001)
                                          : (tmr >= ss_cycles - 24'h000001);

   // limit must persist past 64 consecutive switching cycles
   assign oc_trip = sw_tick & oc_seen & (oc_cnt == `LDOC_OC_LIMIT_CYCLES);

   // per-cycle limit latch and consecutive overcurrent count
   always @(posedge clk_sys) begin
      if (rst || state == ST_STANDBY || state == ST_HICCUP) begin
         oc_seen <= 1'b0;
         oc_cnt <= 7'h00;
         limit_hit <= 1'b0;
      end else if (sw_tick) begin
         oc_seen <= cs_sync;
         limit_hit <= cs_sync;
         if (oc_seen) begin
            if (oc_cnt != `LDOC_OC_LIMIT_CYCLES) begin
               oc_cnt <= oc_cnt + 7'h01;
            end
         end else begin
            oc_cnt <= 7'h00;
         end
      end else if (cs_sync) begin
         oc_seen <= 1'b1;
         limit_hit <= 1'b1;
      end
   end

   // state transitions
   always @* begin
      next_state = state;
      case (state)
         ST_STANDBY: begin
            if (en_sync) begin
               next_state = ST_SOFT;
            end
         end
         ST_SOFT: begin
            if (en_long_low) begin
               next_state = ST_STANDBY;
            end else if (oc_trip) begin
               next_state = ST_HICCUP;
            end else if (tmr_done) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (en_long_low) begin
               next_state = ST_STANDBY;
            end else if (oc_trip) begin
               next_state = ST_HICCUP;
            end
         end
         ST_HICCUP: begin
            if (tmr_done) begin
               next_state = ST_SOFT;
            end
         end
         default: next_state = ST_STANDBY;
      endcase
   end

   // state register and shared soft start / hiccup timer
   always @(posedge clk_sys) begin
      if (rst) begin
         state <= ST_STANDBY;
         tmr <= 24'h000000;
         ss_sel_latched <= 2'h0;
      end else begin
         state <= next_state;
         if (next_state != state) begin
            tmr <= 24'h000000;
            ss_sel_latched <= cfg[`LDOC_CFG_SS_HI:`LDOC_CFG_SS_LO];
         end else if (state == ST_SOFT || state == ST_HICCUP) begin
            if (!tmr_done) begin
               tmr <= tmr + 24'h000001;
            end
         end
      end
   end

   // gate and dimming drives, all registered
   always @(posedge clk_sys) begin
      if (rst) begin
         low_side_gate <= 1'b0;
         high_side_gate <= 1'b0;
         dim_switch_gate_out <= 1'b0;
         dim_gate_drive_strength <= 2'h0;
         fault_flag_1_n <= 1'b1;
         fault_flag_2_n <= 1'b1;
         standby <= 1'b1;
         soft_start_active <= 1'b0;
      end else begin
         // one strength field serves both sources
         dim_gate_drive_strength <= cfg[`LDOC_CFG_DRV_HI:`LDOC_CFG_DRV_LO];
         if (next_state == ST_SOFT || next_state == ST_RUN) begin
            // high here means led switch on (gate pulled below regulator)
            dim_switch_gate_out <= dim_active;
            low_side_gate <= dim_active & req_sync & ~limit_hit & ~cs_sync;
            // high side stays off during soft start to avoid reverse conduction
            high_side_gate <= dim_active & (next_state == ST_RUN) &
                              ~(req_sync & ~limit_hit & ~cs_sync);
         end else begin
            dim_switch_gate_out <= 1'b0;
            low_side_gate <= 1'b0;
            high_side_gate <= 1'b0;
         end
         fault_flag_1_n <= (next_state != ST_HICCUP);
         fault_flag_2_n <= (next_state != ST_HICCUP);
         standby <= (next_state == ST_STANDBY);
         soft_start_active <= (next_state == ST_SOFT);
      end
   end

   // interrupt events
   always @* begin
      irq_set = `LDOC_IRQ_RESET;
      irq_set[`LDOC_IRQ_SHUTDOWN] = (state != ST_HICCUP) & (next_state == ST_HICCUP);
      irq_set[`LDOC_IRQ_RESTART] = (state == ST_HICCUP) & (next_state == ST_SOFT);
      irq_set[`LDOC_IRQ_STANDBY] = (state != ST_STANDBY) & (next_state == ST_STANDBY);
      irq_set[`LDOC_IRQ_LIMIT] = sw_tick & oc_seen;
   end

   // apb decode
   assign apb_access = psel & penable & ~pready;
   assign apb_wr = psel & penable & pready & pwrite;
   assign addr_ok = (paddr == `LDOC_OFS_CONFIG) | (paddr == `LDOC_OFS_DUTY) |
                    (paddr == `LDOC_OFS_STATE) | (paddr == `LDOC_OFS_IRQ_STS) |
                    (paddr == `LDOC_OFS_IRQ_MASK);

   // read mux; unused bits read zero
   assign rd_word = (paddr == `LDOC_OFS_CONFIG) ? {25'h0000000, cfg} :
                    (paddr == `LDOC_OFS_DUTY) ? {24'h000000, duty} :
                    (paddr == `LDOC_OFS_STATE) ? {17'h00000, oc_cnt, dim_active,
                                                  use_internal, limit_hit,
                                                  fault_flag_1_n, soft_start_active,
                                                  standby, state} :
                    (paddr == `LDOC_OFS_IRQ_STS) ? {28'h0000000, irq_sts} :
                    (paddr == `LDOC_OFS_IRQ_MASK) ? {28'h0000000, irq_mask} :
                    32'h00000000;

   // one wait state: ready rises the cycle after the access phase starts
   always @(posedge clk_sys) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (apb_access) begin
         pready <= 1'b1;
         pslverr <= ~addr_ok;
         prdata <= pwrite ? 32'h00000000 : rd_word;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
   end

   // register writes; event set beats a same-cycle write-one clear
   always @(posedge clk_sys) begin
      if (rst) begin
         cfg <= `LDOC_CFG_RESET;
         duty <= `LDOC_DUTY_RESET;
         irq_sts <= `LDOC_IRQ_RESET;
         irq_mask <= `LDOC_IRQ_RESET;
         irq <= 1'b0;
      end else begin
         if (apb_wr && paddr == `LDOC_OFS_CONFIG) begin
            cfg <= pwdata[6:0];
         end
         if (apb_wr && paddr == `LDOC_OFS_DUTY) begin
            duty <= pwdata[7:0];
         end
         if (apb_wr && paddr == `LDOC_OFS_IRQ_MASK) begin
            irq_mask <= pwdata[3:0];
         end
         if (apb_wr && paddr == `LDOC_OFS_IRQ_STS) begin
            irq_sts <= (irq_sts & ~pwdata[3:0]) | irq_set;
         end else begin
            irq_sts <= irq_sts | irq_set;
         end
         irq <= |(irq_sts & irq_mask);
      end
   end

endmodule

// ==== test/ldoc_chk_sva.sv ====
`timescale 1ns/100ps
module ldoc_chk (
   input wire clk_sys,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire pready,
   input wire en_dim_pin,
   input wire switch_clock_pin,
   input wire switch_current_sense,
   input wire low_side_gate,
   input wire high_side_gate,
   input wire dim_switch_gate_out,
   input wire [1:0] dim_gate_drive_strength,
   input wire fault_flag_1_n,
   input wire fault_flag_2_n,
   input wire standby,
   input wire soft_start_active
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   reg wr_cfg = 1'b0;
   // config write completing; strength may only move after one
   always @(posedge clk_sys) begin
      wr_cfg <= psel && penable && pwrite && pready && (paddr == 12'h000);
   end
   a_hiccup_drives_off: assert property (!fault_flag_1_n |->
      !low_side_gate && !high_side_gate && !dim_switch_gate_out) else $error("drive in hiccup");
   a_flags_paired: assert property (fault_flag_1_n == fault_flag_2_n)
      else $error("fault flags differ");
   a_standby_quiet: assert property (standby |->
      !low_side_gate && !high_side_gate && !dim_switch_gate_out) else $error("drive in standby");
   a_enable_low_off: assert property ((!en_dim_pin) [*5] |->
      !dim_switch_gate_out && !low_side_gate && !high_side_gate) else $error("drive with en low");
   a_cycle_limit_cut: assert property ((switch_current_sense && !switch_clock_pin) [*5] |->
      !low_side_gate) else $error("low side on at limit");
   a_standby_cause: assert property ($rose(standby) |-> !en_dim_pin)
      else $error("standby with en high");
   a_restart_soft: assert property ($rose(fault_flag_1_n) |-> ##[0:2] soft_start_active)
      else $error("no soft start after hiccup");
   a_strength_write: assert property ($changed(dim_gate_drive_strength) |->
      wr_cfg || $past(wr_cfg)) else $error("strength moved without write");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than a cycle");
endmodule
bind ldoc_top ldoc_chk u_chk (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pready,
   .en_dim_pin, .switch_clock_pin, .switch_current_sense, .low_side_gate, .high_side_gate,
   .dim_switch_gate_out, .dim_gate_drive_strength, .fault_flag_1_n, .fault_flag_2_n,
   .standby, .soft_start_active);

// ==== test/ldoc_far_side.sv ====
`timescale 1ns/100ps
// power stage beside the block: oscillator, loop request, peak comparator
module ldoc_far_side (
   input wire clk_sys,
   input wire oc_on,
   output reg switch_clock_pin,
   output reg switch_current_sense,
   output reg loop_on_request
);
   reg [3:0] ph = 4'h0;
   initial begin
      switch_clock_pin = 1'b0;
      switch_current_sense = 1'b0;
      loop_on_request = 1'b0;
   end
   // ten-cycle switching period; comparator held high while a fault is wanted
   always @(posedge clk_sys) begin
      ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
      switch_clock_pin <= (ph < 4'h4);
      loop_on_request <= (ph < 4'h7);
      switch_current_sense <= oc_on;
   end
endmodule

// ==== test/led_dimming_and_overcurrent_control_tb_top.sv ====
`timescale 1ns/100ps
module led_dimming_and_overcurrent_control_tb_top;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic en_dim_pin = 1'b0;
   logic dim_source_select_n = 1'b1;
   logic oc_on = 1'b0;
   wire [31:0] prdata;
   wire [1:0] dim_gate_drive_strength;
   wire pready, pslverr, switch_clock_pin, switch_current_sense, loop_on_request;
   wire low_side_gate, high_side_gate, dim_switch_gate_out, fault_flag_1_n, fault_flag_2_n;
   wire standby, soft_start_active, irq;
   integer err_count = 0;
   integer checks = 0;
   logic [31:0] q;
   logic e;
   logic [1:0] sw_seen;
   logic [8:0] rows [0:3];
   always #10 clk_sys = ~clk_sys;
   // short counts keep hiccup, standby and soft start inside the run
   ldoc_top #(.HICCUP_CYCLES(24'd200), .STANDBY_CYCLES(24'd300), .SS_STEP_CYCLES(24'd100)) dut (
      .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .en_dim_pin, .dim_source_select_n, .switch_clock_pin, .switch_current_sense,
      .loop_on_request, .low_side_gate, .high_side_gate, .dim_switch_gate_out,
      .dim_gate_drive_strength, .fault_flag_1_n, .fault_flag_2_n, .standby,
      .soft_start_active, .irq);
   ldoc_far_side u_far (.clk_sys, .oc_on, .switch_clock_pin, .switch_current_sense,
      .loop_on_request);
   task chk(input [31:0] got, input [31:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; values read right after the edge are those sampled at it
   task apb(input w, input [11:0] a, input [31:0] d);
      integer n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         n = n + 1;
      end
      if (n == 20) chk(32'h0, 32'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task done(input [63:0] name);
      $display("test %0s done", name);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #400000;
      err_count = err_count + 1;
      end_sim;
   end
   initial begin
      rows[0] = {7'h00, 2'h0};
      rows[1] = {7'h0A, 2'h1};
      rows[2] = {7'h14, 2'h2};
      rows[3] = {7'h7F, 2'h3};
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk(standby, 1);
      chk(fault_flag_2_n, 1);
      apb(0, 12'h000, 0);
      chk(q, 0);
      apb(0, 12'h004, 0);
      chk(q, 0);
      apb(0, 12'h0FC, 0);
      chk(e, 1);
      chk(q, 0);
      done("reset");
      // drive strength codes, both source settings in the rows
      for (int i = 0; i < 4; i++) begin
         apb(1, 12'h000, {25'h0, rows[i][8:2]});
         apb(0, 12'h000, 0);
         chk(q, {25'h0, rows[i][8:2]});
         chk(dim_gate_drive_strength, rows[i][1:0]);
      end
      apb(1, 12'h000, 0);
      done("table");
      en_dim_pin <= 1'b1;
      repeat (10) @(posedge clk_sys);
      chk({standby, soft_start_active}, 2'b01);
      repeat (100) @(posedge clk_sys);
      chk({soft_start_active, dim_switch_gate_out}, 2'b01);
      // in run both converter gates must switch within one switching period
      sw_seen = 2'b00;
      repeat (10) begin
         @(posedge clk_sys);
         sw_seen = sw_seen | {low_side_gate, high_side_gate};
      end
      chk(sw_seen, 2'b11);
      en_dim_pin <= 1'b0;
      repeat (20) @(posedge clk_sys);
      chk({standby, dim_switch_gate_out, low_side_gate, high_side_gate}, 0);
      en_dim_pin <= 1'b1;
      repeat (10) @(posedge clk_sys);
      chk(dim_switch_gate_out, 1);
      done("extdim");
      dim_source_select_n <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk(dim_switch_gate_out, 0);
      apb(1, 12'h004, 32'h000000C8);
      repeat (10) @(posedge clk_sys);
      chk(dim_switch_gate_out, 1);
      apb(1, 12'h004, 0);
      dim_source_select_n <= 1'b1;
      apb(1, 12'h000, 1);
      repeat (10) @(posedge clk_sys);
      chk(dim_switch_gate_out, 0);
      apb(1, 12'h000, 0);
      repeat (10) @(posedge clk_sys);
      chk(dim_switch_gate_out, 1);
      // 5 percent at 350 Hz: ten 714-cycle steps on, then off to period end
      apb(1, 12'h004, 32'h0000000A);
      apb(1, 12'h000, 32'h00000007);
      repeat (100) @(posedge clk_sys);
      chk(dim_switch_gate_out, 1);
      repeat (7300) @(posedge clk_sys);
      chk(dim_switch_gate_out, 0);
      apb(1, 12'h000, 0);
      apb(1, 12'h004, 0);
      done("intdim");
      apb(1, 12'h010, 32'h0000000F);
      oc_on <= 1'b1;
      repeat (700) @(posedge clk_sys);
      oc_on <= 1'b0;
      chk({fault_flag_1_n, dim_switch_gate_out, high_side_gate, irq}, 4'h1);
      apb(0, 12'h00C, 0);
      chk(q[0], 1);
      repeat (200) @(posedge clk_sys);
      chk({fault_flag_1_n, soft_start_active}, 2'b11);
      apb(0, 12'h00C, 0);
      chk(q[1], 1);
      apb(1, 12'h00C, 32'h0000000F);
      apb(1, 12'h010, 0);
      repeat (3) @(posedge clk_sys);
      chk(irq, 0);
      done("hiccup");
      en_dim_pin <= 1'b0;
      repeat (320) @(posedge clk_sys);
      chk(standby, 1);
      done("standby");
      end_sim;
   end
endmodule
